// ==== src/ssm_params.svh ====
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// instruction codes
`define SSM_CMD_READ 8'h03
`define SSM_CMD_WRITE 8'h02
`define SSM_CMD_MODE_RD 8'h05
`define SSM_CMD_MODE_WR 8'h01
`define SSM_CMD_DUAL 8'h3b
`define SSM_CMD_QUAD 8'h38
`define SSM_CMD_EXIT 8'hff

// operating-mode field, bits 7:6
`define SSM_MODE_HI 7
`define SSM_MODE_LO 6
`define SSM_MODE_BYTE 2'b00
`define SSM_MODE_PAGE 2'b10
`define SSM_MODE_SEQ 2'b01
`define SSM_MODE_RST 8'h40
`define SSM_MODE_RSVD 6'h00

// phase lengths in bits
`define SSM_CMD_BITS 5'd8
`define SSM_ADDR_BITS 5'd24
`define SSM_DUMMY_BITS 5'd8
`define SSM_BYTE_BITS 4'h8

// address space
`define SSM_ARRAY_AW 18
`define SSM_PAGE_AW 5
`define SSM_MEM_AW 6

// link clock made by the host divider
`define SSM_CLK_NS 40
`define SSM_SCK_NS 320
`define SSM_SCK_HALF ((`SSM_SCK_NS / 2) / `SSM_CLK_NS)

`endif

// ==== src/ssm_pkg.sv ====
package ssm_pkg;

  // lane width, code equals bits per link clock
  typedef enum logic [2:0] {
    SSM_W1 = 3'h1,
    SSM_W2 = 3'h2,
    SSM_W4 = 3'h4
  } ssm_width_e;

  typedef enum logic [5:0] {
    SSM_D_CMD = 6'h01,
    SSM_D_ADDR = 6'h02,
    SSM_D_DUMMY = 6'h04,
    SSM_D_WDATA = 6'h08,
    SSM_D_RDATA = 6'h10,
    SSM_D_SKIP = 6'h20
  } ssm_dst_e;

  typedef enum logic [7:0] {
    SSM_H_IDLE = 8'h01,
    SSM_H_CMD = 8'h02,
    SSM_H_ADDR = 8'h04,
    SSM_H_DUMMY = 8'h08,
    SSM_H_WDATA = 8'h10,
    SSM_H_RDATA = 8'h20,
    SSM_H_ENDF = 8'h40,
    SSM_H_GAP = 8'h80
  } ssm_hst_e;

  typedef struct packed {
    logic sck_a;
    logic sck_b;
    logic sck_c;
    logic cs_a;
    logic cs_b;
    logic [3:0] io_a;
    logic [3:0] io_b;
    ssm_dst_e st;
    ssm_width_e wid;
    logic [7:0] mode;
    logic [17:0] addr;
    logic rd;
    logic tgt_mode;
    logic sent;
    logic [23:0] sh;
    logic [4:0] cnt;
    logic [7:0] osh;
    logic [3:0] ocnt;
    logic oe;
  } ssm_dev_s;

  typedef struct packed {
    logic [3:0] io_a;
    logic [3:0] io_b;
    ssm_hst_e st;
    ssm_width_e wid;
    logic [2:0] hcnt;
    logic sck;
    logic cs_n;
    logic [7:0] cmd;
    logic [23:0] sh;
    logic [4:0] cnt;
    logic [3:0] o;
    logic oe;
    logic [7:0] rsh;
    logic [7:0] rdata;
    logic rvalid;
    logic wtake;
    logic [7:0] left;
  } ssm_host_s;

  // lanes a party drives; single-bit host uses line 0, device line 1
  function automatic logic [3:0] ssm_lanes(input ssm_width_e w, input logic is_dev);
    logic [3:0] m;
    m = 4'hf;
    if (w == SSM_W1) begin
      m = is_dev ? 4'h2 : 4'h1;
    end else if (w == SSM_W2) begin
      m = 4'h3;
    end
    return m;
  endfunction

endpackage

// ==== src/ssm_link_if.sv ====
`timescale 1ns/1ps
interface ssm_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  wire [3:0] io;

  // resolved line level, pulled high when nobody drives
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign io[i] = dev_io_oe[i] ? dev_io_o[i] : (host_io_oe[i] ? host_io_o[i] : 1'b1);
  end

  modport host (output cs_n, output sck, output host_io_o, output host_io_oe, input io);
  modport dev (input cs_n, input sck, input io, output dev_io_o, output dev_io_oe);
endinterface

// ==== src/ssm_host.sv ====
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_host
  import ssm_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, high
  ssm_link_if.host link, // serial link
  input wire logic start_i, // begin a frame
  input wire logic [7:0] cmd_i, // instruction byte
  input wire logic [17:0] addr_i, // array address
  input wire logic [7:0] wdata_i, // next byte to send
  input wire logic [7:0] nbytes_i, // data bytes in frame
  output logic busy_o, // frame in progress
  output logic wtake_o, // wdata_i taken
  output logic [7:0] rdata_o, // received byte
  output logic rvalid_o, // rdata_o new
  output logic [2:0] width_o // bits per clock now
);

  ssm_host_s host_ff;
  ssm_host_s nxt_host;
  logic [4:0] cntn;
  logic [7:0] rshn;

  function automatic logic [3:0] top_bits(input logic [23:0] v, input ssm_width_e w);
    logic [3:0] t;
    t = v[23:20];
    if (w == SSM_W1) begin
      t = {3'h0, v[23]};
    end else if (w == SSM_W2) begin
      t = {2'h0, v[23:22]};
    end
    return t;
  endfunction

  // frame sequencing on the divided link clock
  always_comb begin
    nxt_host = host_ff;
    nxt_host.rvalid = 1'b0;
    nxt_host.wtake = 1'b0;
    nxt_host.io_a = link.io;
    nxt_host.io_b = host_ff.io_a;
    cntn = host_ff.cnt + {2'h0, host_ff.wid};
    unique case (host_ff.wid)
      SSM_W2: rshn = {host_ff.rsh[5:0], host_ff.io_b[1:0]};
      SSM_W4: rshn = {host_ff.rsh[3:0], host_ff.io_b};
      default: rshn = {host_ff.rsh[6:0], host_ff.io_b[1]};
    endcase
    if (host_ff.st == SSM_H_IDLE) begin
      if (start_i) begin
        nxt_host.st = SSM_H_CMD;
        nxt_host.cs_n = 1'b0;
        nxt_host.cmd = cmd_i;
        nxt_host.left = nbytes_i;
        nxt_host.cnt = 5'h0;
        nxt_host.hcnt = 3'h0;
        nxt_host.oe = 1'b1;
        nxt_host.o = top_bits({cmd_i, 16'h0}, host_ff.wid);
        nxt_host.sh = {cmd_i, 16'h0} << host_ff.wid;
      end
    end else if (host_ff.hcnt != 3'(`SSM_SCK_HALF - 1)) begin
      nxt_host.hcnt = host_ff.hcnt + 3'h1;
    end else begin
      nxt_host.hcnt = 3'h0;
      unique case (host_ff.st)
        SSM_H_ENDF: begin
          nxt_host.sck = 1'b0;
          // last bit already taken, by the device or in a read by the host; free the lines
          nxt_host.oe = 1'b0;
          if (!host_ff.sck) begin
            nxt_host.cs_n = 1'b1;
            nxt_host.oe = 1'b0;
            nxt_host.st = SSM_H_GAP;
          end
        end
        SSM_H_GAP: nxt_host.st = SSM_H_IDLE;
        default: begin
          nxt_host.sck = ~host_ff.sck;
          if (host_ff.sck) begin
            // falling edge: next bits out, msb first
            nxt_host.o = top_bits(host_ff.sh, host_ff.wid);
            nxt_host.sh = host_ff.sh << host_ff.wid;
            // lines released half a clock after the last bit was taken
            if (host_ff.st == SSM_H_DUMMY || host_ff.st == SSM_H_RDATA) begin
              nxt_host.oe = 1'b0;
            end
            // read bits taken at the end of the high phase; at the rise the
            // device output has not yet crossed the two-stage line sync
            if (host_ff.st == SSM_H_RDATA && host_ff.cnt != 5'h0) begin
              nxt_host.rsh = rshn;
              if (host_ff.cnt == `SSM_CMD_BITS) begin
                nxt_host.cnt = 5'h0;
                nxt_host.rdata = rshn;
                nxt_host.rvalid = 1'b1;
                nxt_host.left = host_ff.left - 8'h01;
                if (host_ff.left <= 8'h01) begin
                  nxt_host.st = SSM_H_ENDF;
                end
              end
            end
          end else begin
            nxt_host.cnt = cntn;
            unique case (host_ff.st)
              SSM_H_CMD: begin
                if (cntn == `SSM_CMD_BITS) begin
                  nxt_host.cnt = 5'h0;
                  nxt_host.st = SSM_H_ENDF;
                  case (host_ff.cmd)
                    `SSM_CMD_READ, `SSM_CMD_WRITE: begin
                      nxt_host.st = SSM_H_ADDR;
                      nxt_host.sh = {6'h00, addr_i};
                    end
                    `SSM_CMD_MODE_RD: begin
                      nxt_host.st = SSM_H_RDATA;
                    end
                    `SSM_CMD_MODE_WR: begin
                      nxt_host.st = SSM_H_WDATA;
                      nxt_host.left = 8'h01;
                      nxt_host.sh = {wdata_i & {2'b11, `SSM_MODE_RSVD}, 16'h0};
                      nxt_host.wtake = 1'b1;
                    end
                    `SSM_CMD_DUAL: nxt_host.wid = SSM_W2;
                    `SSM_CMD_QUAD: nxt_host.wid = SSM_W4;
                    `SSM_CMD_EXIT: nxt_host.wid = SSM_W1;
                    default: nxt_host.st = SSM_H_ENDF;
                  endcase
                end
              end
              SSM_H_ADDR: begin
                if (cntn == `SSM_ADDR_BITS) begin
                  nxt_host.cnt = 5'h0;
                  if (host_ff.cmd == `SSM_CMD_READ) begin
                    nxt_host.st = SSM_H_DUMMY;
                  end else begin
                    nxt_host.st = SSM_H_WDATA;
                    nxt_host.sh = {wdata_i, 16'h0};
                    nxt_host.wtake = 1'b1;
                  end
                end
              end
              SSM_H_DUMMY: begin
                if (cntn == `SSM_DUMMY_BITS) begin
                  nxt_host.cnt = 5'h0;
                  nxt_host.st = SSM_H_RDATA;
                end
              end
              SSM_H_WDATA: begin
                if (cntn == `SSM_CMD_BITS) begin
                  nxt_host.cnt = 5'h0;
                  nxt_host.left = host_ff.left - 8'h01;
                  if (host_ff.left <= 8'h01) begin
                    nxt_host.st = SSM_H_ENDF;
                  end else begin
                    nxt_host.sh = {wdata_i, 16'h0};
                    nxt_host.wtake = 1'b1;
                  end
                end
              end
              default: begin
                // read: only count here, bits are taken before the next fall
                nxt_host.cnt = cntn;
              end
            endcase
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_ff <= '{st: SSM_H_IDLE, wid: SSM_W1, cs_n: 1'b1, default: '0};
    end else begin
      host_ff <= nxt_host;
    end
  end

  // link pins and user outputs
  assign link.cs_n = host_ff.cs_n;
  assign link.sck = host_ff.sck;
  assign link.host_io_o = host_ff.o;
  assign link.host_io_oe = host_ff.oe ? ssm_lanes(host_ff.wid, 1'b0) : 4'h0;
  assign busy_o = host_ff.st != SSM_H_IDLE;
  assign wtake_o = host_ff.wtake;
  assign rdata_o = host_ff.rdata;
  assign rvalid_o = host_ff.rvalid;
  assign width_o = host_ff.wid;

endmodule // ssm_host

// ==== src/ssm_dev.sv ====
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_dev
  import ssm_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, high
  ssm_link_if.dev link, // serial link
  output logic [7:0] mode_o, // operating-mode register
  output logic [2:0] width_o, // bits per clock now
  output logic selected_o // chip select seen low
);

  ssm_dev_s dev_ff;
  ssm_dev_s nxt_dev;
  logic [7:0] mem [0:(1 << `SSM_MEM_AW) - 1];
  logic rise;
  logic fall;
  logic [23:0] shn;
  logic [4:0] cntn;
  logic [17:0] nxt_addr;
  logic we;
  logic [`SSM_MEM_AW-1:0] waddr;
  logic [7:0] wdat;

  // link edges from the synchronised clock
  assign rise = dev_ff.sck_b & ~dev_ff.sck_c;
  assign fall = ~dev_ff.sck_b & dev_ff.sck_c;

  // address step per operating mode
  always_comb begin
    if (dev_ff.mode[`SSM_MODE_HI:`SSM_MODE_LO] == `SSM_MODE_PAGE) begin
      nxt_addr = {dev_ff.addr[`SSM_ARRAY_AW-1:`SSM_PAGE_AW],
                  dev_ff.addr[`SSM_PAGE_AW-1:0] + 5'h01};
    end else begin
      nxt_addr = dev_ff.addr + 18'h00001;
    end
  end

  // input shift in the current width
  always_comb begin
    unique case (dev_ff.wid)
      SSM_W2: shn = {dev_ff.sh[21:0], dev_ff.io_b[1:0]};
      SSM_W4: shn = {dev_ff.sh[19:0], dev_ff.io_b};
      default: shn = {dev_ff.sh[22:0], dev_ff.io_b[0]};
    endcase
    cntn = dev_ff.cnt + {2'h0, dev_ff.wid};
  end

  // command, address and data sequencing
  always_comb begin
    nxt_dev = dev_ff;
    we = 1'b0;
    waddr = dev_ff.addr[`SSM_MEM_AW-1:0];
    wdat = shn[7:0];
    nxt_dev.sck_a = link.sck;
    nxt_dev.sck_b = dev_ff.sck_a;
    nxt_dev.sck_c = dev_ff.sck_b;
    nxt_dev.cs_a = link.cs_n;
    nxt_dev.cs_b = dev_ff.cs_a;
    nxt_dev.io_a = link.io;
    nxt_dev.io_b = dev_ff.io_a;
    if (dev_ff.cs_b) begin
      // deselected: drop any partial sequence
      nxt_dev.st = SSM_D_CMD;
      nxt_dev.cnt = 5'h0;
      nxt_dev.ocnt = 4'h0;
      nxt_dev.oe = 1'b0;
    end else if (rise) begin
      // capture on the rising edge
      unique case (dev_ff.st)
        SSM_D_CMD: begin
          nxt_dev.sh = shn;
          nxt_dev.cnt = cntn;
          if (cntn == `SSM_CMD_BITS) begin
            nxt_dev.cnt = 5'h0;
            nxt_dev.tgt_mode = 1'b0;
            nxt_dev.sent = 1'b0;
            nxt_dev.st = SSM_D_SKIP;
            case (shn[7:0])
              `SSM_CMD_READ: begin
                nxt_dev.st = SSM_D_ADDR;
                nxt_dev.rd = 1'b1;
              end
              `SSM_CMD_WRITE: begin
                nxt_dev.st = SSM_D_ADDR;
                nxt_dev.rd = 1'b0;
              end
              `SSM_CMD_MODE_RD: begin
                nxt_dev.st = SSM_D_RDATA;
                nxt_dev.tgt_mode = 1'b1;
              end
              `SSM_CMD_MODE_WR: begin
                nxt_dev.st = SSM_D_WDATA;
                nxt_dev.tgt_mode = 1'b1;
              end
              `SSM_CMD_DUAL: nxt_dev.wid = SSM_W2;
              `SSM_CMD_QUAD: nxt_dev.wid = SSM_W4;
              `SSM_CMD_EXIT: nxt_dev.wid = SSM_W1;
              default: nxt_dev.st = SSM_D_SKIP;
            endcase
          end
        end
        SSM_D_ADDR: begin
          nxt_dev.sh = shn;
          nxt_dev.cnt = cntn;
          if (cntn == `SSM_ADDR_BITS) begin
            // top six address bits are dropped
            nxt_dev.addr = shn[`SSM_ARRAY_AW-1:0];
            nxt_dev.cnt = 5'h0;
            nxt_dev.st = dev_ff.rd ? SSM_D_DUMMY : SSM_D_WDATA;
          end
        end
        SSM_D_DUMMY: begin
          // one dummy byte: 8, 4 or 2 clocks by width
          nxt_dev.cnt = cntn;
          if (cntn == `SSM_DUMMY_BITS) begin
            nxt_dev.cnt = 5'h0;
            nxt_dev.st = SSM_D_RDATA;
          end
        end
        SSM_D_WDATA: begin
          nxt_dev.sh = shn;
          nxt_dev.cnt = cntn;
          if (cntn == `SSM_CMD_BITS) begin
            nxt_dev.cnt = 5'h0;
            if (dev_ff.tgt_mode) begin
              // only the mode field is kept; reserved bits read zero
              nxt_dev.mode = {shn[`SSM_MODE_HI:`SSM_MODE_LO], `SSM_MODE_RSVD};
              nxt_dev.st = SSM_D_SKIP;
            end else begin
              we = 1'b1;
              nxt_dev.addr = nxt_addr;
              if (dev_ff.mode[`SSM_MODE_HI:`SSM_MODE_LO] == `SSM_MODE_BYTE) begin
                nxt_dev.st = SSM_D_SKIP;
              end
            end
          end
        end
        default: nxt_dev.st = dev_ff.st;
      endcase
    end else if (fall && dev_ff.st == SSM_D_RDATA) begin
      // drive new bits after the falling edge
      if (dev_ff.ocnt != 4'h0) begin
        nxt_dev.osh = dev_ff.osh << dev_ff.wid;
        nxt_dev.ocnt = dev_ff.ocnt - {1'b0, dev_ff.wid};
      end else if (dev_ff.sent && !dev_ff.tgt_mode &&
                   dev_ff.mode[`SSM_MODE_HI:`SSM_MODE_LO] == `SSM_MODE_BYTE) begin
        // byte mode: one byte per read
        nxt_dev.st = SSM_D_SKIP;
        nxt_dev.oe = 1'b0;
      end else begin
        nxt_dev.osh = dev_ff.tgt_mode ? dev_ff.mode : mem[dev_ff.addr[`SSM_MEM_AW-1:0]];
        nxt_dev.ocnt = `SSM_BYTE_BITS - {1'b0, dev_ff.wid};
        nxt_dev.oe = 1'b1;
        nxt_dev.sent = 1'b1;
        if (!dev_ff.tgt_mode) begin
          nxt_dev.addr = nxt_addr;
        end
      end
    end
  end

  // state register; mode field starts sequential
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dev_ff <= '{st: SSM_D_CMD, wid: SSM_W1, mode: `SSM_MODE_RST, cs_a: 1'b1, cs_b: 1'b1,
                  default: '0};
    end else begin
      dev_ff <= nxt_dev;
    end
  end

  // storage window of the array, no reset
  always_ff @(posedge clock_i) begin
    if (we) begin
      mem[waddr] <= wdat;
    end
  end

  // output lanes in the current width
  always_comb begin
    unique case (dev_ff.wid)
      SSM_W2: link.dev_io_o = {2'h0, dev_ff.osh[7:6]};
      SSM_W4: link.dev_io_o = dev_ff.osh[7:4];
      default: link.dev_io_o = {2'h0, dev_ff.osh[7], 1'b0};
    endcase
  end

  // lines released while deselected
  assign link.dev_io_oe = (dev_ff.oe && !dev_ff.cs_b) ? ssm_lanes(dev_ff.wid, 1'b1) : 4'h0;
  assign mode_o = dev_ff.mode;
  assign width_o = dev_ff.wid;
  assign selected_o = ~dev_ff.cs_b;

endmodule // ssm_dev

// ==== testbench/ssm_link_assertions.sv ====
`timescale 1ns/1ps
module ssm_link_assertions (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic cs_n, // chip select, low active
  input wire logic sck, // link clock
  input wire logic [3:0] host_io_o, // host data
  input wire logic [3:0] host_io_oe, // host enables
  input wire logic [3:0] dev_io_o, // device data
  input wire logic [3:0] dev_io_oe // device enables
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // link-level checks
  dev_release_a: assert property (cs_n [*4] |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  no_contention_a: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("both ends drive one line");
  host_lanes_a: assert property (host_io_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("host lane set illegal");
  dev_lanes_a: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("device lane set illegal");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("link clock runs while deselected");
  sck_half_a: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
    else $error("link clock high phase wrong");
  host_hold_a: assert property (sck && $past(sck) && host_io_oe == $past(host_io_oe) |->
    (host_io_o & host_io_oe) == ($past(host_io_o) & host_io_oe)) else $error("host data moved while clock high");
  dev_hold_a: assert property (sck && $past(sck) && dev_io_oe == $past(dev_io_oe) |->
    (dev_io_o & dev_io_oe) == ($past(dev_io_o) & dev_io_oe)) else $error("device data moved while clock high");
  cmd_quiet_a: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*8])
    else $error("device drives during command");

  // lane widths seen in use
  cover property (dev_io_oe == 4'h2);
  cover property (dev_io_oe == 4'h3);
  cover property (dev_io_oe == 4'hf);
endmodule // ssm_link_assertions

// ==== testbench/serial_sram_mode_and_io_width_tb.sv ====
`timescale 1ns/1ps
module serial_sram_mode_and_io_width_tb;
  import ssm_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [7:0] cmd_i = 8'h00;
  logic [17:0] addr_i = 18'h00000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] nbytes_i = 8'h01;
  logic busy_o, wtake_o, rvalid_o, selected_o;
  logic [7:0] rdata_o, mode_o;
  logic [2:0] width_o, dev_width_o;
  logic [7:0] rq[$];
  logic [7:0] wmode[3] = '{8'h00, 8'h80, 8'h40};
  logic [7:0] wcmd[2] = '{8'h3b, 8'h38};
  logic [7:0] wwid[2] = '{8'h02, 8'h04};
  logic [7:0] wbase[2] = '{8'he0, 8'hf0};
  int err_count = 0;
  int comparisons = 0;

  ssm_link_if link();
  ssm_host i_ssm_host (.clock_i(clock_i), .rst_i(rst_i), .link(link), .start_i(start_i), .cmd_i(cmd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .nbytes_i(nbytes_i), .busy_o(busy_o), .wtake_o(wtake_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .width_o(width_o));
  ssm_dev i_ssm_dev (.clock_i(clock_i), .rst_i(rst_i), .link(link), .mode_o(mode_o), .width_o(dev_width_o),
    .selected_o(selected_o));
  ssm_link_assertions i_ssm_link_assertions (.clock_i(clock_i), .rst_i(rst_i), .cs_n(link.cs_n), .sck(link.sck),
    .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o),
    .dev_io_oe(link.dev_io_oe));

  // 25 MHz system clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read bytes against an incrementing pattern
  task automatic seq_chk(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) begin
      chk(rq[k], b + 8'(k));
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one host frame; write bytes count up from wd, read bytes gather in rq
  task automatic run(input logic [7:0] c, input logic [17:0] a, input logic [7:0] n, input logic [7:0] wd);
    rq.delete();
    @(posedge clock_i);
    start_i <= 1'b1;
    cmd_i <= c;
    addr_i <= a;
    nbytes_i <= n;
    wdata_i <= wd;
    @(posedge clock_i);
    start_i <= 1'b0;
    do begin
      @(posedge clock_i);
      if (rvalid_o === 1'b1) begin
        rq.push_back(rdata_o);
      end
      if (wtake_o === 1'b1) begin
        wdata_i <= wdata_i + 8'h01;
      end
    end while (busy_o !== 1'b0);
  endtask

  // hang guard
  initial begin
    repeat (80000) @(posedge clock_i);
    err_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk(mode_o, 8'h40);
    fork
      run(8'h05, 18'h00000, 8'h01, 8'h00);
      begin
        repeat (8) @(posedge clock_i);
        chk({7'h00, selected_o}, 8'h01);
      end
    join
    chk(rq[0], 8'h40);
    // every mode value written, then read back
    foreach (wmode[i]) begin
      run(8'h01, 18'h00000, 8'h01, wmode[i]);
      chk(mode_o, wmode[i]);
      run(8'h05, 18'h00000, 8'h01, 8'h00);
      chk(rq[0], wmode[i]);
    end
    // page mode wraps to page start
    run(8'h01, 18'h00000, 8'h01, 8'h80);
    run(8'h02, 18'h0001e, 8'h04, 8'ha0);
    run(8'h03, 18'h0001e, 8'h04, 8'h00);
    seq_chk(4, 8'ha0);
    run(8'h01, 18'h00000, 8'h01, 8'h40);
    run(8'h03, 18'h00000, 8'h02, 8'h00);
    seq_chk(2, 8'ha2);
    // sequential rollover at the top address
    run(8'h02, 18'h3ffff, 8'h02, 8'hb0);
    run(8'h03, 18'h3ffff, 8'h02, 8'h00);
    seq_chk(2, 8'hb0);
    // byte mode stores one byte and reads one byte, then the line floats high
    run(8'h02, 18'h00005, 8'h02, 8'hd0);
    run(8'h01, 18'h00000, 8'h01, 8'h00);
    run(8'h02, 18'h00005, 8'h02, 8'hc0);
    run(8'h03, 18'h00005, 8'h02, 8'h00);
    chk(rq[0], 8'hc0);
    chk(rq[1], 8'hff);
    run(8'h01, 18'h00000, 8'h01, 8'h40);
    run(8'h03, 18'h00005, 8'h02, 8'h00);
    chk(rq[0], 8'hc0);
    chk(rq[1], 8'hd1);
    // dual then quad: enter, move data, read mode, leave
    foreach (wcmd[i]) begin
      run(wcmd[i], 18'h00000, 8'h01, 8'h00);
      chk({5'h00, dev_width_o}, wwid[i]);
      chk({5'h00, width_o}, wwid[i]);
      run(8'h02, 18'h00010, 8'h03, wbase[i]);
      run(8'h03, 18'h00010, 8'h03, 8'h00);
      seq_chk(3, wbase[i]);
      run(8'h05, 18'h00000, 8'h01, 8'h00);
      chk(rq[0], 8'h40);
      run(8'hff, 18'h00000, 8'h01, 8'h00);
      chk({5'h00, dev_width_o}, 8'h01);
      run(8'h03, 18'h00011, 8'h01, 8'h00);
      chk(rq[0], wbase[i] + 8'h01);
    end
    // reset in quad width restores defaults
    run(8'h01, 18'h00000, 8'h01, 8'h80);
    run(8'h38, 18'h00000, 8'h01, 8'h00);
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    chk({5'h00, dev_width_o}, 8'h01);
    chk(mode_o, 8'h40);
    run(8'h05, 18'h00000, 8'h01, 8'h00);
    chk(rq[0], 8'h40);
    chk({7'h00, selected_o}, 8'h00);
    print_verdict();
  end
endmodule // serial_sram_mode_and_io_width_tb
